/* core/wdrc_params.svh */
// Purpose: Constants for the watchdog with reset cause block.
// Assumes: Byte addresses on a 32-bit AHB-Lite data bus.
// Notes:   Register indices are scaled by four into byte addresses.
`ifndef WDRC_PARAMS_SVH
`define WDRC_PARAMS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define WDRC_IDX_SYSTEM_CONTROL_STATUS     16'h0013
`define WDRC_IDX_SERVICE  16'h1ff0
`define WDRC_ADDR_SYSTEM_CONTROL_STATUS    16'h004c
`define WDRC_ADDR_SERVICE 16'h7fc0
`define WDRC_ADDR_ISTAT   16'h0080
`define WDRC_ADDR_IMASK   16'h0084

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define WDRC_SVC_BIT      0
`define WDRC_RATE_RESET   2'h0
`define WDRC_NUM_EVT      4
`define WDRC_EVT_RESET    4'h0
`define WDRC_RATE_MAX     2'h3

// ****************************************************************
// Timing
// ****************************************************************
// Kept in microseconds so that the tick count stays an integer.
`define WDRC_BASE_TIMEOUT_US 1000000
`define WDRC_TICK_PERIOD_US  62500
`define WDRC_BASE_TICKS (`WDRC_BASE_TIMEOUT_US / `WDRC_TICK_PERIOD_US)

`endif

/* core/wdrc_pkg.sv */
// Purpose: Types shared by the watchdog with reset cause block.
// Assumes: Nothing beyond the constants header.
// Notes:   Field order matches the bit order of the registers.
`default_nettype none

package wdrc_pkg;

    // ************************************************************
    // Control and status register layout, high bits first downward.
    // ************************************************************
    typedef struct packed {
        logic       illegal_stop_cause;
        logic       bad_address_cause;
        logic       watchdog_cause;
        logic       timeout_rate_hi;
        logic       timeout_rate_lo;
    } wdrc_system_control_status_t;

    // Sticky event layout used by interrupt status and mask.
    typedef struct packed {
        logic       ext_reset;
        logic       illegal_stop;
        logic       bad_address;
        logic       timeout;
    } wdrc_evt_t;

    typedef enum {
        WDRC_SEL_NONE,
        WDRC_SEL_SYSTEM_CONTROL_STATUS,
        WDRC_SEL_SERVICE,
        WDRC_SEL_ISTAT,
        WDRC_SEL_IMASK
    } wdrc_sel_t;

endpackage

`default_nettype wire

/* core/wdrc_top.sv */
// Purpose: Watchdog timer that records the cause of the last reset.
// Assumes: One clock; periodic tick is a one-cycle enable pulse.
// Notes:   Registers are reached over an AHB-Lite slave port.
//
// Overview of operation
// - Unserviced watchdog forces full system reset.
// - Counter advanced by each periodic tick.
// - Writing zero to service bit restarts countdown.
// - Counter held cleared in reset or stop.
// - Illegal stop flag set, cleared by watchdog and external resets.
// - Bad address flag set, cleared by watchdog and external resets.
// - Watchdog cause flag set, cleared by bad address and external resets.
// - Watchdog resets only with option; unstoppable.
// - Rate field accepted only on first write.
// - Unwritten rate stays zero, one second timeout.
// - Writing rate clears the counter chain.
// - Bit set/clear is read-modify-write; locks rate.
// - Rates give 1, 2, 4, 8 seconds.
// - Wait mode keeps watchdog counting.
// - Stop mode halts watchdog counting.
`include "wdrc_params.svh"
`default_nettype none

module wdrc_top #(
    parameter bit WDOG_PRESENT = 1'b1,
    parameter bit STOP_ENABLED = 1'b1,
    parameter int BASE_TICKS   = `WDRC_BASE_TICKS,
    parameter int CNT_W        = 8
) (
    input  wire  logic        hclk,
    input  wire  logic        hresetn,
    input  wire  logic        hsel,
    input  wire  logic [31:0] haddr,
    input  wire  logic [1:0]  htrans,
    input  wire  logic        hwrite,
    input  wire  logic [2:0]  hsize,
    input  wire  logic [31:0] hwdata,
    input  wire  logic        hready,
    output var   logic [31:0] hrdata,
    output var   logic        hreadyout,
    output var   logic        hresp,
    input  wire  logic        periodic_tick_source,
    input  wire  logic        stop_mode,
    input  wire  logic        wait_mode,
    input  wire  logic        cpu_in_reset,
    input  wire  logic        stop_exec,
    input  wire  logic        bad_address_event,
    input  wire  logic        ext_reset_event,
    output var   logic        sys_reset_req,
    output var   logic        irq
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    generate
        if (BASE_TICKS < 1 || CNT_W < 2 || CNT_W > 31) begin : g_bad_w
            $error("wdrc_top: BASE_TICKS or CNT_W out of range");
        end
        // The longest limit must still fit, or the shift drops its upper bits.
        if ((BASE_TICKS * 8) >= (2 ** CNT_W)) begin : g_bad_fit
            $error("wdrc_top: CNT_W too small for the 8 second rate");
        end
    endgenerate

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic wdrc_pkg::wdrc_sel_t decode(
        input logic [31:0] addr
    );
        wdrc_pkg::wdrc_sel_t s;
        s = wdrc_pkg::WDRC_SEL_NONE;
        case (addr[15:0])
            `WDRC_ADDR_SYSTEM_CONTROL_STATUS:    s = wdrc_pkg::WDRC_SEL_SYSTEM_CONTROL_STATUS;
            `WDRC_ADDR_SERVICE: s = wdrc_pkg::WDRC_SEL_SERVICE;
            `WDRC_ADDR_ISTAT:   s = wdrc_pkg::WDRC_SEL_ISTAT;
            `WDRC_ADDR_IMASK:   s = wdrc_pkg::WDRC_SEL_IMASK;
            default:            s = wdrc_pkg::WDRC_SEL_NONE;
        endcase
        return s;
    endfunction

    logic                  ap_take;
    logic                  ap_read;
    wdrc_pkg::wdrc_sel_t   ap_sel;
    logic                  dp_write;
    wdrc_pkg::wdrc_sel_t   dp_sel;
    logic                  wr_system_control_status;
    logic                  wr_service;
    logic                  wr_imask;
    logic                  rd_istat;

    logic [1:0]            rate;
    logic                  rate_locked;
    logic                  watchdog_cause;
    logic                  bad_address_cause;
    logic                  illegal_stop_cause;
    logic [CNT_W-1:0]      cnt;
    logic [CNT_W-1:0]      limit;
    logic                  hold_clear;
    logic                  wdog_fire;
    logic                  stop_illegal;
    logic                  any_reset;
    wdrc_pkg::wdrc_evt_t   evt;
    wdrc_pkg::wdrc_evt_t   istat;
    wdrc_pkg::wdrc_evt_t   imask;
    wdrc_pkg::wdrc_system_control_status_t  system_control_status_view;

    assign ap_take = hsel && hready && htrans[1];
    assign ap_read = ap_take && !hwrite;
    assign ap_sel  = decode(haddr);

    // ************************************************************
    // AHB-Lite data phase tracking
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_sel   <= wdrc_pkg::WDRC_SEL_NONE;
        end else begin
            dp_write <= ap_take && hwrite;
            dp_sel   <= ap_take ? ap_sel : wdrc_pkg::WDRC_SEL_NONE;
        end
    end

    assign wr_system_control_status    = dp_write && (dp_sel == wdrc_pkg::WDRC_SEL_SYSTEM_CONTROL_STATUS);
    assign wr_service = dp_write && (dp_sel == wdrc_pkg::WDRC_SEL_SERVICE);
    assign wr_imask   = dp_write && (dp_sel == wdrc_pkg::WDRC_SEL_IMASK);
    assign rd_istat   = ap_read && (ap_sel == wdrc_pkg::WDRC_SEL_ISTAT);

    // Zero wait states and an OKAY answer to every access.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ************************************************************
    // Reset sources
    // ************************************************************
    // The option is a fabrication choice, so no register can reach it.
    assign wdog_fire    = WDOG_PRESENT && periodic_tick_source
                          && !hold_clear
                          && (cnt >= limit - 1'b1);
    assign stop_illegal = stop_exec && !STOP_ENABLED;
    assign any_reset    = wdog_fire || bad_address_event
                          || stop_illegal || ext_reset_event;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_reset_req <= 1'b0;
        end else begin
            sys_reset_req <= any_reset;
        end
    end

    // ************************************************************
    // Reset cause flags
    // ************************************************************
    // Power-on reset is hresetn and clears all three flags.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            watchdog_cause     <= 1'b0;
            bad_address_cause  <= 1'b0;
            illegal_stop_cause <= 1'b0;
        end else if (wdog_fire) begin
            watchdog_cause     <= 1'b1;
            bad_address_cause  <= 1'b0;
            illegal_stop_cause <= 1'b0;
        end else if (bad_address_event) begin
            watchdog_cause     <= 1'b0;
            bad_address_cause  <= 1'b1;
        end else if (stop_illegal) begin
            illegal_stop_cause <= 1'b1;
        end else if (ext_reset_event) begin
            watchdog_cause     <= 1'b0;
            bad_address_cause  <= 1'b0;
            illegal_stop_cause <= 1'b0;
        end
    end

    // ************************************************************
    // Timeout rate, writable once after any reset
    // ************************************************************
    // A set or clear of one bit arrives as a whole-word write of the
    // value read back, so it locks the rate at what it already holds.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rate        <= `WDRC_RATE_RESET;
            rate_locked <= 1'b0;
        end else if (any_reset) begin
            rate        <= `WDRC_RATE_RESET;
            rate_locked <= 1'b0;
        end else if (wr_system_control_status && !rate_locked) begin
            rate        <= hwdata[1:0];
            rate_locked <= 1'b1;
        end
    end

    // ************************************************************
    // Watchdog counter chain
    // ************************************************************
    // Each rate step doubles the number of ticks to a timeout.
    assign limit = CNT_W'(BASE_TICKS) << rate;
    // Stop shuts the oscillator; wait_mode deliberately has no effect.
    assign hold_clear = cpu_in_reset || stop_mode;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= '0;
        end else if (hold_clear || any_reset) begin
            cnt <= '0;
        end else if (wr_service && !hwdata[`WDRC_SVC_BIT]) begin
            cnt <= '0;
        end else if (wr_system_control_status && !rate_locked) begin
            cnt <= '0;
        end else if (periodic_tick_source) begin
            cnt <= cnt + 1'b1;
        end
    end

    // ************************************************************
    // Interrupt status and mask
    // ************************************************************
    assign evt.timeout      = wdog_fire;
    assign evt.bad_address  = bad_address_event;
    assign evt.illegal_stop = stop_illegal;
    assign evt.ext_reset    = ext_reset_event;

    // A read clears the status, but an event in that same cycle wins.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            istat <= `WDRC_EVT_RESET;
        end else if (rd_istat) begin
            istat <= evt;
        end else begin
            istat <= istat | evt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            imask <= `WDRC_EVT_RESET;
        end else if (wr_imask) begin
            imask <= hwdata[`WDRC_NUM_EVT-1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |((istat | evt) & imask & ~({`WDRC_NUM_EVT{rd_istat}}
                     & ~evt));
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    assign system_control_status_view.illegal_stop_cause = illegal_stop_cause;
    assign system_control_status_view.bad_address_cause  = bad_address_cause;
    assign system_control_status_view.watchdog_cause     = watchdog_cause;
    assign system_control_status_view.timeout_rate_hi    = rate[1];
    assign system_control_status_view.timeout_rate_lo    = rate[0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (ap_read) begin
            case (ap_sel)
                wdrc_pkg::WDRC_SEL_SYSTEM_CONTROL_STATUS:
                    hrdata <= {27'h0, system_control_status_view};
                wdrc_pkg::WDRC_SEL_ISTAT:
                    hrdata <= {28'h0, istat};
                wdrc_pkg::WDRC_SEL_IMASK:
                    hrdata <= {28'h0, imask};
                default:
                    hrdata <= '0;
            endcase
        end
    end

endmodule // wdrc_top

`default_nettype wire

/* verif/wdrc_checker.sv */
// Purpose: Port assertions for the watchdog with reset cause block.
// Assumes: Ticks come at least two cycles apart; BASE_TICKS above 1.
// Notes:   Two tick counters bound the timeout from below and above.
`include "wdrc_params.svh"
`default_nettype none
module wdrc_checker #(
    parameter bit WDOG_PRESENT = 1'b1,
    parameter bit STOP_ENABLED = 1'b1,
    parameter int BASE_TICKS   = 2
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        periodic_tick_source,
    input wire logic        stop_mode,
    input wire logic        cpu_in_reset,
    input wire logic        stop_exec,
    input wire logic        bad_address_event,
    input wire logic        ext_reset_event,
    input wire logic        sys_reset_req
);
    // ************************************************************
    // Tick counters
    // ************************************************************
    // The low counter ignores rate writes, so it never undercounts.
    logic       src, hold, clr, wr_ph, svc_ph, system_control_status_ph;
    logic [7:0] cnt_lo, cnt_hi;
    assign src = bad_address_event | ext_reset_event | stop_exec;
    assign hold = stop_mode | cpu_in_reset;
    assign clr = src | hold | sys_reset_req | (svc_ph & ~hwdata[0]);
    assign wr_ph = hsel & hready & htrans[1] & hwrite;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            svc_ph <= 1'b0;
            system_control_status_ph <= 1'b0;
        end else begin
            svc_ph <= wr_ph && haddr[15:0] == `WDRC_ADDR_SERVICE;
            system_control_status_ph <= wr_ph && haddr[15:0] == `WDRC_ADDR_SYSTEM_CONTROL_STATUS;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) cnt_lo <= 8'h00;
        else if (clr) cnt_lo <= 8'h00;
        else if (periodic_tick_source) cnt_lo <= cnt_lo + 8'h01;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) cnt_hi <= 8'h00;
        else if (clr || system_control_status_ph) cnt_hi <= 8'h00;
        else if (periodic_tick_source) cnt_hi <= cnt_hi + 8'h01;
    end
    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    min_span_a: assert property (
        sys_reset_req && !$past(src) |-> int'(cnt_lo) >= BASE_TICKS)
        else $error("watchdog fired too early");
    max_span_a: assert property (
        !WDOG_PRESENT || int'(cnt_hi) <= 8 * BASE_TICKS)
        else $error("watchdog failed to fire");
    hold_quiet_a: assert property (
        $past(hold) && !$past(src) |-> !sys_reset_req)
        else $error("watchdog fired while held");
    bad_req_a: assert property (
        bad_address_event |=> sys_reset_req)
        else $error("no reset after bad address");
    ext_req_a: assert property (
        ext_reset_event |=> sys_reset_req)
        else $error("no reset after external event");
    stop_req_a: assert property (
        stop_exec && !STOP_ENABLED |=> sys_reset_req)
        else $error("no reset after illegal stop");
    option_only_a: assert property (
        sys_reset_req |-> WDOG_PRESENT || $past(src))
        else $error("watchdog reset without option");
    req_pulse_a: assert property (
        sys_reset_req && !src |=> !sys_reset_req)
        else $error("reset request longer than one cycle");
    fire_c: cover property (sys_reset_req && !$past(src));
    hold_c: cover property (hold && periodic_tick_source);
    bad_c: cover property (bad_address_event);
endmodule // wdrc_checker
bind wdrc_top wdrc_checker #(.WDOG_PRESENT(WDOG_PRESENT),
    .STOP_ENABLED(STOP_ENABLED), .BASE_TICKS(BASE_TICKS)) u_wdrc_checker (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .periodic_tick_source(periodic_tick_source), .stop_mode(stop_mode),
    .cpu_in_reset(cpu_in_reset), .stop_exec(stop_exec),
    .bad_address_event(bad_address_event),
    .ext_reset_event(ext_reset_event), .sys_reset_req(sys_reset_req));
`default_nettype wire

/* verif/wdrc_top_bench.sv */
// Purpose: Self-checking bench for the watchdog with reset cause.
// Assumes: Base count of two ticks; the stop option is off.
// Notes:   Ticks are three cycles apart so counts stay exact.
`include "wdrc_params.svh"
`default_nettype none
module wdrc_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BASE = 2;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        tick, stop_mode, wait_mode, cpu_in_reset, stop_exec;
    logic        bad_ev, ext_ev, sys_req, irq;
    int          errors, cmp_count, n;
    assign hready = hreadyout;
    wdrc_top #(.STOP_ENABLED(1'b0), .BASE_TICKS(BASE)) u_wdrc_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .periodic_tick_source(tick),
        .stop_mode(stop_mode), .wait_mode(wait_mode),
        .cpu_in_reset(cpu_in_reset), .stop_exec(stop_exec),
        .bad_address_event(bad_ev), .ext_reset_event(ext_ev),
        .sys_reset_req(sys_req), .irq(irq));
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic results();
        $display("Compares %0d, errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] system_control_status(input logic [1:0] r,
                                         input logic [2:0] f);
        return {27'h0, f, r};
    endfunction
    task automatic bus(input logic [15:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {16'h0000, a};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // Returns max + 1 in n when no reset request came.
    task automatic ticks(input int max);
        n = 0;
        while (n < max) begin
            @(posedge hclk) tick <= 1'b1;
            wait_mode <= 1'($urandom);
            @(posedge hclk) tick <= 1'b0;
            n++;
            @(posedge hclk);
            if (sys_req === 1'b1) return;
        end
        n = max + 1;
    endtask
    task automatic pulse(input int which);
        @(posedge hclk);
        if (which == 0) bad_ev <= 1'b1;
        else if (which == 1) ext_ev <= 1'b1;
        else stop_exec <= 1'b1;
        @(posedge hclk);
        {bad_ev, ext_ev, stop_exec} <= 3'b000;
        @(posedge hclk);
        check({31'h0, sys_req}, 32'h1);
    endtask
    initial begin
        #400000;
        errors++;
        results();
    end
    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {errors, cmp_count, haddr, hwdata, hsel, htrans, hwrite} = '0;
        {tick, stop_mode, wait_mode, cpu_in_reset, hresetn} = '0;
        {stop_exec, bad_ev, ext_ev} = '0;
        hsize = 3'b010;
        rd = $urandom(88678);
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        bus(`WDRC_ADDR_SYSTEM_CONTROL_STATUS, 1'b0, 32'h0);
        check(rd, system_control_status(2'h0, 3'h0));
        ticks(64); check(n, BASE);
        bus(16'h0100, 1'b0, 32'h0);
        check(rd, 32'h0);
        ticks(BASE - 1);
        bus(`WDRC_ADDR_SERVICE, 1'b1, 32'hfffffffe);
        ticks(64); check(n, BASE);
        ticks(BASE - 1);
        bus(`WDRC_ADDR_SERVICE, 1'b1, 32'h1);
        ticks(64); check(n, 1);
        for (int h = 0; h < 2; h++) begin
            ticks(BASE - 1);
            bus(`WDRC_ADDR_SERVICE, 1'b1, 32'h0);
            @(posedge hclk) {cpu_in_reset, stop_mode} <= 2'(h + 1);
            ticks(3); check(n, 4);
            @(posedge hclk) {cpu_in_reset, stop_mode} <= 2'b00;
            ticks(64); check(n, BASE);
        end
        for (int r = 0; r < 4; r++) begin
            pulse(1);
            ticks(BASE - 1);
            bus(`WDRC_ADDR_SYSTEM_CONTROL_STATUS, 1'b1, ($urandom & ~32'h3) | r);
            bus(`WDRC_ADDR_SYSTEM_CONTROL_STATUS, 1'b1, ($urandom & ~32'h3) | (3 - r));
            bus(`WDRC_ADDR_SYSTEM_CONTROL_STATUS, 1'b0, 32'h0);
            check(rd, system_control_status(2'(r), 3'h0));
            ticks(64); check(n, BASE << r);
            bus(`WDRC_ADDR_SYSTEM_CONTROL_STATUS, 1'b0, 32'h0);
            check(rd, system_control_status(2'h0, 3'b001));
        end
        pulse(0);
        bus(`WDRC_ADDR_SYSTEM_CONTROL_STATUS, 1'b0, 32'h0);
        check(rd, system_control_status(2'h0, 3'b010));
        pulse(2);
        bus(`WDRC_ADDR_SYSTEM_CONTROL_STATUS, 1'b0, 32'h0);
        check(rd, system_control_status(2'h0, 3'b110));
        ticks(64);
        bus(`WDRC_ADDR_SYSTEM_CONTROL_STATUS, 1'b0, 32'h0);
        check(rd, system_control_status(2'h0, 3'b001));
        pulse(1);
        bus(`WDRC_ADDR_SYSTEM_CONTROL_STATUS, 1'b0, 32'h0);
        bus(`WDRC_ADDR_SYSTEM_CONTROL_STATUS, 1'b1, rd);
        bus(`WDRC_ADDR_SYSTEM_CONTROL_STATUS, 1'b1, 32'h3);
        bus(`WDRC_ADDR_SYSTEM_CONTROL_STATUS, 1'b0, 32'h0);
        check(rd, system_control_status(2'h0, 3'h0));
        bus(`WDRC_ADDR_ISTAT, 1'b0, 32'h0);
        bus(`WDRC_ADDR_IMASK, 1'b1, 32'h0);
        pulse(0);
        @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        bus(`WDRC_ADDR_IMASK, 1'b1, 32'h2);
        repeat (2) @(posedge hclk);
        check({31'h0, irq}, 32'h1);
        bus(`WDRC_ADDR_ISTAT, 1'b0, 32'h0);
        check(rd, 32'h2);
        repeat (2) @(posedge hclk);
        check({31'h0, irq}, 32'h0);
        check({30'h0, hresp, hreadyout}, 32'h1);
        results();
    end
endmodule // wdrc_top_bench
`default_nettype wire
